// ---- rtl/aishp_pkg.sv ----
package aishp_pkg;
  // ==========================================================
  // register map
  localparam logic [6:0] ANALOGUE_PATH_CONTROL_IDX = 7'h04;
  localparam logic [6:0] DIGITAL_PATH_CONTROL_IDX = 7'h05;
  localparam logic [6:0] RATE_CONTROL_IDX = 7'h08;
  localparam logic [6:0] POWER_CONTROL_IDX = 7'h06;
  localparam logic [6:0] STATUS_IDX = 7'h0a;
  localparam int REG_W = 9;
  // ==========================================================
  // field positions
  localparam int MIC_GAIN_BOOST_BIT = 0;
  localparam int MIC_TO_ADC_SILENCE_BIT = 1;
  localparam int ADC_SOURCE_PICK_BIT = 2;
  localparam int HIGHPASS_OFF_BIT = 0;
  localparam int OFFSET_HOLD_BIT = 4;
  localparam int STANDBY_BIT = 0;
  // ==========================================================
  // reset values
  localparam logic [8:0] ANALOGUE_PATH_RESET = 9'h002;
  localparam logic [8:0] DIGITAL_PATH_RESET = 9'h000;
  localparam logic [8:0] RATE_RESET = 9'h000;
  localparam logic [8:0] POWER_RESET = 9'h000;
  // ==========================================================
  // filter
  localparam int SAMPLE_W = 24;
  localparam int HPF_SHIFT = 10;
  localparam logic [3:0] RATE_FAST_LIMIT = 4'h7;
  typedef enum logic [0:0] {AISHP_FILT_NORMAL, AISHP_FILT_FAST} aishp_filt_type;
endpackage

// ---- rtl/aishp_dc_remover.sv ----
`timescale 1ns/1ps
module aishp_dc_remover #(
  parameter int W = 24,
  parameter int SHIFT = 10
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_valid,
  input wire logic signed [W-1:0] in_sample,
  input wire logic hpf_on,
  input wire logic hold,
  output logic out_valid,
  output logic signed [W-1:0] out_sample
);
  logic signed [W+SHIFT-1:0] acc, next_acc;
  logic next_out_valid;
  logic signed [W-1:0] next_out_sample;
  logic signed [W-1:0] est;
  logic signed [W:0] diff;

  // ==========================================================
  // offset estimate and subtraction
  always_comb begin
    // a cleared offset must not reach the very first sample after the switch
    est = (hpf_on || hold) ? acc[W+SHIFT-1:SHIFT] : '0;
    diff = {in_sample[W-1], in_sample} - {est[W-1], est};
    next_acc = acc;
    next_out_valid = in_valid;
    next_out_sample = out_sample;
    if (in_valid) begin
      // saturate so a large step cannot wrap
      if (diff > $signed({2'b00, {(W-1){1'b1}}})) begin
        next_out_sample = {1'b0, {(W-1){1'b1}}};
      end else if (diff < $signed({2'b11, {(W-1){1'b0}}})) begin
        next_out_sample = {1'b1, {(W-1){1'b0}}};
      end else begin
        next_out_sample = diff[W-1:0];
      end
      if (hpf_on) begin
        next_acc = acc + (W+SHIFT)'(diff);
      end else if (hold) begin
        next_acc = acc;
      end else begin
        next_acc = '0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc <= '0;
      out_valid <= 1'b0;
      out_sample <= '0;
    end else begin
      acc <= next_acc;
      out_valid <= next_out_valid;
      out_sample <= next_out_sample;
    end
  end
endmodule

// ---- rtl/aishp_top.sv ----
`timescale 1ns/1ps
module aishp_top
  import aishp_pkg::*;
#(
  parameter int DECIM = 64,
  parameter int SAMPLE_W = aishp_pkg::SAMPLE_W,
  parameter int MOD_W = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [6:0] reg_addr,
  input wire logic [aishp_pkg::REG_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [aishp_pkg::REG_W-1:0] reg_rdata,
  input wire logic mod_valid,
  input wire logic signed [MOD_W-1:0] mod_left,
  input wire logic signed [MOD_W-1:0] mod_right,
  output logic out_valid,
  output logic signed [SAMPLE_W-1:0] out_left,
  output logic signed [SAMPLE_W-1:0] out_right,
  output logic adc_source_pick,
  output logic mic_gain_boost,
  output logic mic_to_adc_silence,
  output logic electret_supply_out,
  output logic filter_fast
);
  import aishp_pkg::*;

  // ==========================================================
  // register file
  logic [REG_W-1:0] analogue_path_control, next_analogue_path_control;
  logic [REG_W-1:0] digital_path_control, next_digital_path_control;
  logic [REG_W-1:0] rate_control, next_rate_control;
  logic [REG_W-1:0] power_control, next_power_control;
  logic [REG_W-1:0] next_reg_rdata;

  always_comb begin
    next_analogue_path_control = analogue_path_control;
    next_digital_path_control = digital_path_control;
    next_rate_control = rate_control;
    next_power_control = power_control;
    if (reg_wr) begin
      case (reg_addr)
        ANALOGUE_PATH_CONTROL_IDX: next_analogue_path_control = reg_wdata;
        DIGITAL_PATH_CONTROL_IDX: next_digital_path_control = reg_wdata;
        RATE_CONTROL_IDX: next_rate_control = reg_wdata;
        POWER_CONTROL_IDX: next_power_control = reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // sample boundary and settings snapshot
  localparam int CW = $clog2(DECIM);
  logic [CW-1:0] dec_cnt, next_dec_cnt;
  logic boundary;
  logic hpf_on, next_hpf_on;
  logic hold, next_hold;
  logic src_mic, next_src_mic;
  logic fast, next_fast;
  logic [REG_W-1:0] status_word;

  assign boundary = mod_valid && (dec_cnt == CW'(DECIM - 1));

  always_comb begin
    next_dec_cnt = dec_cnt;
    next_hpf_on = hpf_on;
    next_hold = hold;
    next_src_mic = src_mic;
    next_fast = fast;
    if (mod_valid) begin
      next_dec_cnt = boundary ? '0 : dec_cnt + 1'b1;
    end
    // latch only between output words so one sample never mixes settings
    if (boundary) begin
      next_hpf_on = !digital_path_control[HIGHPASS_OFF_BIT];
      next_hold = digital_path_control[OFFSET_HOLD_BIT];
      next_src_mic = analogue_path_control[ADC_SOURCE_PICK_BIT];
      next_fast = (rate_control[3:0] > RATE_FAST_LIMIT);
    end
  end

  always_comb begin
    status_word = '0;
    status_word[0] = hpf_on;
    status_word[1] = hold;
    status_word[2] = src_mic;
    status_word[3] = fast;
    next_reg_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        ANALOGUE_PATH_CONTROL_IDX: next_reg_rdata = analogue_path_control;
        DIGITAL_PATH_CONTROL_IDX: next_reg_rdata = digital_path_control;
        RATE_CONTROL_IDX: next_reg_rdata = rate_control;
        POWER_CONTROL_IDX: next_reg_rdata = power_control;
        STATUS_IDX: next_reg_rdata = status_word;
        default: next_reg_rdata = '0;
      endcase
    end
  end

  // ==========================================================
  // decimator: boxcar sum over DECIM modulator words
  // a plain boxcar trades stopband depth for size
  localparam int AW = SAMPLE_W;
  logic signed [AW-1:0] acc_l, next_acc_l, acc_r, next_acc_r;
  logic signed [AW-1:0] dec_l, dec_r, next_dec_l, next_dec_r;
  logic dec_valid, next_dec_valid;

  always_comb begin
    next_acc_l = acc_l;
    next_acc_r = acc_r;
    next_dec_l = dec_l;
    next_dec_r = dec_r;
    next_dec_valid = 1'b0;
    if (mod_valid) begin
      if (boundary) begin
        // sum scaled up to 24-bit full scale
        next_dec_l = (acc_l + AW'(mod_left)) <<< (AW - MOD_W - CW);
        next_dec_r = (acc_r + AW'(mod_right)) <<< (AW - MOD_W - CW);
        next_dec_valid = 1'b1;
        next_acc_l = '0;
        next_acc_r = '0;
      end else begin
        next_acc_l = acc_l + AW'(mod_left);
        next_acc_r = acc_r + AW'(mod_right);
      end
    end
  end

  // ==========================================================
  // dc removal per channel
  logic [1:0] hv;
  logic signed [SAMPLE_W-1:0] hl, hr;

  // both channels see the same snapshot
  aishp_dc_remover #(.W(SAMPLE_W), .SHIFT(HPF_SHIFT)) u_left (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(dec_valid),
    .in_sample(dec_l),
    .hpf_on(hpf_on),
    .hold(hold),
    .out_valid(hv[0]),
    .out_sample(hl)
  );

  aishp_dc_remover #(.W(SAMPLE_W), .SHIFT(HPF_SHIFT)) u_right (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(dec_valid),
    .in_sample(dec_r),
    .hpf_on(hpf_on),
    .hold(hold),
    .out_valid(hv[1]),
    .out_sample(hr)
  );

  // ==========================================================
  // output registers
  logic next_out_valid;
  logic signed [SAMPLE_W-1:0] next_out_left, next_out_right;
  logic next_adc_source_pick, next_mic_gain_boost, next_mic_to_adc_silence;
  logic next_electret_supply_out;

  always_comb begin
    next_out_valid = hv[0];
    next_out_left = hv[0] ? hl : out_left;
    next_out_right = hv[1] ? hr : out_right;
    next_adc_source_pick = src_mic;
    next_mic_gain_boost = analogue_path_control[MIC_GAIN_BOOST_BIT];
    // silences converter feed only; sidetone taps before this switch
    next_mic_to_adc_silence = analogue_path_control[MIC_TO_ADC_SILENCE_BIT];
    next_electret_supply_out = !power_control[STANDBY_BIT];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      analogue_path_control <= ANALOGUE_PATH_RESET;
      digital_path_control <= DIGITAL_PATH_RESET;
      rate_control <= RATE_RESET;
      power_control <= POWER_RESET;
      reg_rdata <= '0;
      dec_cnt <= '0;
      hpf_on <= 1'b1;
      hold <= 1'b0;
      src_mic <= 1'b0;
      fast <= 1'b0;
      acc_l <= '0;
      acc_r <= '0;
      dec_l <= '0;
      dec_r <= '0;
      dec_valid <= 1'b0;
      out_valid <= 1'b0;
      out_left <= '0;
      out_right <= '0;
      adc_source_pick <= 1'b0;
      mic_gain_boost <= 1'b0;
      mic_to_adc_silence <= 1'b1;
      electret_supply_out <= 1'b1;
      filter_fast <= 1'b0;
    end else begin
      analogue_path_control <= next_analogue_path_control;
      digital_path_control <= next_digital_path_control;
      rate_control <= next_rate_control;
      power_control <= next_power_control;
      reg_rdata <= next_reg_rdata;
      dec_cnt <= next_dec_cnt;
      hpf_on <= next_hpf_on;
      hold <= next_hold;
      src_mic <= next_src_mic;
      fast <= next_fast;
      acc_l <= next_acc_l;
      acc_r <= next_acc_r;
      dec_l <= next_dec_l;
      dec_r <= next_dec_r;
      dec_valid <= next_dec_valid;
      out_valid <= next_out_valid;
      out_left <= next_out_left;
      out_right <= next_out_right;
      adc_source_pick <= next_adc_source_pick;
      mic_gain_boost <= next_mic_gain_boost;
      mic_to_adc_silence <= next_mic_to_adc_silence;
      electret_supply_out <= next_electret_supply_out;
      filter_fast <= fast;
    end
  end
endmodule

// ---- tb/aishp_assertions.sv ----
`timescale 1ns/1ps
module aishp_checker
  import aishp_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [6:0] reg_addr,
  input wire logic [8:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [8:0] reg_rdata,
  input wire logic out_valid,
  input wire logic adc_source_pick,
  input wire logic mic_gain_boost,
  input wire logic mic_to_adc_silence,
  input wire logic electret_supply_out,
  input wire logic filter_fast
);
  // ==========================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_quiet;
    !out_valid [*3];
  endsequence
  sequence s_ana_wr;
    reg_wr && reg_addr == ANALOGUE_PATH_CONTROL_IDX;
  endsequence
  property p_pulse;
    out_valid |=> s_quiet;
  endproperty
  property p_boost;
    s_ana_wr |=> ##1 mic_gain_boost == $past(reg_wdata[MIC_GAIN_BOOST_BIT], 2);
  endproperty
  property p_silence;
    s_ana_wr |=> ##1 mic_to_adc_silence == $past(reg_wdata[MIC_TO_ADC_SILENCE_BIT], 2);
  endproperty
  property p_bias;
    reg_wr && reg_addr == POWER_CONTROL_IDX
      |=> ##1 electret_supply_out != $past(reg_wdata[STANDBY_BIT], 2);
  endproperty
  // source and type move only next to a sample boundary, never mid-sample
  property p_src;
    !$stable(adc_source_pick) |-> ##[0:3] out_valid;
  endproperty
  property p_fast;
    !$stable(filter_fast) |-> ##[0:3] out_valid;
  endproperty
  property p_idle;
    !reg_rd |=> reg_rdata == 9'h000;
  endproperty
  property p_readback;
    reg_rd && reg_addr == ANALOGUE_PATH_CONTROL_IDX
      |=> reg_rdata[1:0] == {mic_to_adc_silence, mic_gain_boost};
  endproperty
  a_pulse: assert property (p_pulse) else $error("sample pulses too close");
  a_boost: assert property (p_boost) else $error("boost not following write");
  a_silence: assert property (p_silence) else $error("silence not following write");
  a_bias: assert property (p_bias) else $error("bias not following standby");
  a_src: assert property (p_src) else $error("source moved off boundary");
  a_fast: assert property (p_fast) else $error("filter type moved off boundary");
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  a_readback: assert property (p_readback) else $error("readback differs");
endmodule

bind aishp_top aishp_checker u_chk (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .out_valid(out_valid), .adc_source_pick(adc_source_pick), .mic_gain_boost(mic_gain_boost),
  .mic_to_adc_silence(mic_to_adc_silence), .electret_supply_out(electret_supply_out),
  .filter_fast(filter_fast));

// ---- tb/aishp_mod_model.sv ----
`timescale 1ns/1ps
module aishp_mod_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic slow,
  input wire logic signed [3:0] level,
  output logic mod_valid,
  output logic signed [3:0] mod_left,
  output logic signed [3:0] mod_right
);
  // stalled cycles carry the inverse, so stale words are never counted
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mod_valid <= 1'b0;
      mod_left <= 4'h0;
      mod_right <= 4'h0;
    end else begin
      mod_valid <= slow ? ~mod_valid : 1'b1;
      mod_left <= (slow && mod_valid) ? ~level : level;
      mod_right <= (slow && mod_valid) ? ~level : level;
    end
  end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import aishp_pkg::*;
  logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, slow = 0;
  logic [6:0] reg_addr = 7'h00;
  logic [8:0] reg_wdata = 9'h000;
  logic [8:0] reg_rdata;
  logic signed [3:0] level = 4'h1;
  logic mod_valid, out_valid, src, boost, sil, bias, fast;
  logic signed [3:0] mod_left, mod_right;
  logic signed [23:0] out_left, out_right, held;
  int mismatches = 0, n_checks = 0;
  aishp_top #(.DECIM(4)) u_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mod_valid(mod_valid), .mod_left(mod_left), .mod_right(mod_right),
    .out_valid(out_valid), .out_left(out_left), .out_right(out_right),
    .adc_source_pick(src), .mic_gain_boost(boost), .mic_to_adc_silence(sil),
    .electret_supply_out(bias), .filter_fast(fast));
  aishp_mod_model u_mod (.clk(clk), .arst_n(arst_n), .slow(slow), .level(level),
    .mod_valid(mod_valid), .mod_left(mod_left), .mod_right(mod_right));
  initial begin
    forever #2 clk = ~clk;
  end
  // ==========================================================
  // helpers
  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [8:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check("reg", {15'h0, reg_rdata}, {15'h0, exp});
  endtask
  task automatic wait_s(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(posedge clk);
        #1;
        k++;
      end while (out_valid !== 1'b1 && k < 200);
      if (k >= 200) mismatches++;
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd(ANALOGUE_PATH_CONTROL_IDX, 9'h002);
    rd(DIGITAL_PATH_CONTROL_IDX, 9'h000);
    check("src", {23'h0, src}, 24'h0);
    check("bias", {23'h0, bias}, 24'h1);
    $display("test reset done");
  endtask
  task automatic t_controls();
    wr(ANALOGUE_PATH_CONTROL_IDX, 9'h005);
    rd(ANALOGUE_PATH_CONTROL_IDX, 9'h005);
    wait_s(2);
    check("src", {23'h0, src}, 24'h1);
    check("boost", {23'h0, boost}, 24'h1);
    check("sil", {23'h0, sil}, 24'h0);
    wr(POWER_CONTROL_IDX, 9'h001);
    rd(7'h7f, 9'h000);
    check("bias", {23'h0, bias}, 24'h0);
    wr(POWER_CONTROL_IDX, 9'h000);
    wr(RATE_CONTROL_IDX, 9'h008);
    wait_s(2);
    check("fast", {23'h0, fast}, 24'h1);
    wr(RATE_CONTROL_IDX, 9'h007);
    wait_s(2);
    check("fast", {23'h0, fast}, 24'h0);
    $display("test controls done");
  endtask
  task automatic t_offset();
    wr(DIGITAL_PATH_CONTROL_IDX, 9'h001);
    wait_s(3);
    check("raw", out_left, 24'h100000);
    check("right", out_right, 24'h100000);
    wr(DIGITAL_PATH_CONTROL_IDX, 9'h000);
    // estimate settles with a 1024-sample time constant
    wait_s(7000);
    check("hpf", {23'h0, out_left < 24'sd4096 && out_left > -24'sd4096}, 24'h1);
    wr(DIGITAL_PATH_CONTROL_IDX, 9'h011);
    @(posedge clk);
    level <= 4'h2;
    slow <= 1'b1;
    wait_s(3);
    held = out_left;
    check("hold", {23'h0, held > 24'sh0f0000 && held < 24'sh110000}, 24'h1);
    wait_s(20);
    check("frozen", out_left, held);
    wr(DIGITAL_PATH_CONTROL_IDX, 9'h001);
    wait_s(3);
    check("clear", out_left, 24'h200000);
    $display("test offset done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_controls();
    t_offset();
    finish_test();
  end
  initial begin
    #(50000 * 4);
    mismatches++;
    finish_test();
  end
endmodule
